// File: rtl/css_params.svh
/*
  Constants for the clock source select and start-up block: register
  offsets, field positions, fuse reset values and start-up counts.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH

// register byte offsets on the AXI4-Lite slave
`define CSS_ADDR_CTRL 4'h0
`define CSS_ADDR_STAT 4'h4
`define CSS_ADDR_FUSE 4'h8

// control register field positions
`define CSS_CTRL_MODE_LSB 0
`define CSS_CTRL_ASYNC 3
`define CSS_CTRL_SLEEP 4

// control register reset values
`define CSS_MODE_RST 3'h0
`define CSS_ASYNC_RST 1'h0

// fuse values as delivered (1 = unprogrammed)
`define CSS_SEL_RST 4'h1
`define CSS_STARTUP_RST 2'h2
`define CSS_AMP_RST 1'h1

// wake-up counts in selected-source cycles
`define CSS_WAKE_258 15'h0102
`define CSS_WAKE_1K 15'h0400
`define CSS_WAKE_16K 15'h4000
`define CSS_WAKE_RC 15'h0006

// reset delay counts in watchdog oscillator cycles
`define CSS_RST_4K 17'h0_1000
`define CSS_RST_64K 17'h1_0000

// bus responses
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_DECERR 2'h3

`endif

// File: rtl/css_pkg.sv
/*
  Types for the clock source select and start-up block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package css_pkg;

  // raw fuse set, each bit 1 when unprogrammed
  typedef struct packed {
    logic [3:0] clock_source_select;
    logic [1:0] startup_time_select;
    logic oscillator_amplifier_option;
  } css_fuse_s;

  // per-domain clock enables
  typedef struct packed {
    logic core_clock;
    logic program_memory_clock;
    logic peripheral_clock;
    logic async_timer_clock;
    logic converter_clock;
  } css_gates_s;

  typedef enum logic [2:0] {
    CSS_SRC_CRYSTAL = 3'h0,
    CSS_SRC_LOWFREQ = 3'h1,
    CSS_SRC_EXT_RC = 3'h2,
    CSS_SRC_INT_RC = 3'h3,
    CSS_SRC_EXT_CLK = 3'h4
  } css_source_e;

  typedef enum logic [2:0] {
    CSS_SLP_IDLE = 3'h0,
    CSS_SLP_CONV_NR = 3'h1,
    CSS_SLP_PWR_DOWN = 3'h2,
    CSS_SLP_PWR_SAVE = 3'h3,
    CSS_SLP_STANDBY = 3'h6
  } css_sleep_e;

  typedef enum logic [4:0] {
    CSS_ST_LOAD = 5'b00001,
    CSS_ST_START = 5'b00010,
    CSS_ST_RUN = 5'b00100,
    CSS_ST_SLEEP = 5'b01000,
    CSS_ST_WAKE = 5'b10000
  } css_state_e;

  typedef enum logic [1:0] {
    CSS_WK_258 = 2'h0,
    CSS_WK_1K = 2'h1,
    CSS_WK_16K = 2'h2,
    CSS_WK_RC = 2'h3
  } css_wake_e;

  typedef enum logic [1:0] {
    CSS_RD_NONE = 2'h0,
    CSS_RD_4K = 2'h1,
    CSS_RD_64K = 2'h2
  } css_rdly_e;

  typedef enum logic [2:0] {
    CSS_RNG_NONE = 3'h0,
    CSS_RNG_0P4 = 3'h1,
    CSS_RNG_0P9 = 3'h2,
    CSS_RNG_3P0 = 3'h3,
    CSS_RNG_WIDE = 3'h4
  } css_range_e;

endpackage

// File: rtl/css_clock_control.sv
/*
  Clock source select and start-up control: samples the fuses after
  reset, times the reset and wake-up delays, gates the domain clocks
  per sleep mode and exposes control and status over AXI4-Lite.
  Assumes source_tick pulses once per selected-source cycle and
  watchdog_osc_tick once per watchdog oscillator cycle, both aligned
  to aclk; wake inputs come from logic that runs unclocked.
*/
// Design decisions made here: register access over AXI4-Lite and the register offsets.
// Overview of operation
// - gate unused domain clocks per sleep mode
// - core logic idles while core clock stopped
// - external interrupt wakes without peripheral clock
// - two-wire address match wakes in every mode
// - program memory clock follows core clock
// - async timer only under internal RC
// - converter clock runs while core, program memory and peripheral clocks halt
// - four select fuses pick the source
// - fuse bit 1 unprogrammed, 0 programmed
// - wake counts selected-source cycles before execution
// - reset adds no, 4K or 64K watchdog cycles
// - delivered fuses 0001 and startup 10
// - amplifier fuse sets swing and range
// - crystal upper select bits set range
// - select low bit plus startup pick delays
// - low bit 0 delay table
// - low bit 1 delay table
`timescale 1ns/1ps
`default_nettype none
`include "css_params.svh"
module css_clock_control #(
  parameter logic [14:0] WAKE_LONG = `CSS_WAKE_16K,
  parameter logic [16:0] RST_LONG = `CSS_RST_64K
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fuses and oscillator ticks
  input wire css_pkg::css_fuse_s fuse_pins,
  input wire logic source_tick,
  input wire logic watchdog_osc_tick,
  // wake sources
  input wire logic external_interrupt_async,
  input wire logic two_wire_address_match,
  input wire logic async_timer_wake,
  // clock domains and oscillator setup
  output css_pkg::css_gates_s clock_gate,
  output logic execution_enable,
  output logic oscillator_full_swing,
  output css_pkg::css_range_e osc_range
);
  // source kind from the select fuses
  function automatic css_pkg::css_source_e src_kind(
    input logic [3:0] s);
    if (s >= 4'hA) return css_pkg::CSS_SRC_CRYSTAL;
    if (s == 4'h9) return css_pkg::CSS_SRC_LOWFREQ;
    if (s >= 4'h5) return css_pkg::CSS_SRC_EXT_RC;
    if (s >= 4'h1) return css_pkg::CSS_SRC_INT_RC;
    return css_pkg::CSS_SRC_EXT_CLK;
  endfunction
  // wake-up count choice
  function automatic css_pkg::css_wake_e wake_sel(
    input css_pkg::css_fuse_s f);
    logic [2:0] idx;
    idx = {f.clock_source_select[0], f.startup_time_select};
    if (src_kind(f.clock_source_select) != css_pkg::CSS_SRC_CRYSTAL)
      return css_pkg::CSS_WK_RC;
    if (idx <= 3'h1) return css_pkg::CSS_WK_258;
    if (idx <= 3'h4) return css_pkg::CSS_WK_1K;
    return css_pkg::CSS_WK_16K;
  endfunction
  // extra reset delay choice
  function automatic css_pkg::css_rdly_e rdly_sel(
    input css_pkg::css_fuse_s f);
    logic [2:0] idx;
    idx = {f.clock_source_select[0], f.startup_time_select};
    if (src_kind(f.clock_source_select) != css_pkg::CSS_SRC_CRYSTAL)
      idx = {1'b1, f.startup_time_select} + 3'h1;
    unique case (idx)
      3'h0, 3'h3, 3'h6: return css_pkg::CSS_RD_4K;
      3'h1, 3'h4, 3'h7: return css_pkg::CSS_RD_64K;
      default: return css_pkg::CSS_RD_NONE;
    endcase
  endfunction
  // wake count in cycles
  function automatic logic [14:0] wake_len(input css_pkg::css_wake_e w);
    unique case (w)
      css_pkg::CSS_WK_258: return `CSS_WAKE_258;
      css_pkg::CSS_WK_1K: return `CSS_WAKE_1K;
      css_pkg::CSS_WK_16K: return WAKE_LONG;
      default: return `CSS_WAKE_RC;
    endcase
  endfunction
  // reset delay in watchdog cycles
  function automatic logic [16:0] rdly_len(input css_pkg::css_rdly_e r);
    unique case (r)
      css_pkg::CSS_RD_4K: return `CSS_RST_4K;
      css_pkg::CSS_RD_64K: return RST_LONG;
      default: return 17'h0_0000;
    endcase
  endfunction
  // registers
  css_pkg::css_state_e state_ff, nxt_state;
  css_pkg::css_fuse_s fuse_ff;
  logic [14:0] wake_cnt_ff, nxt_wake_cnt;
  logic [16:0] rst_cnt_ff, nxt_rst_cnt;
  logic [2:0] mode_ff;
  logic async_en_ff, sleep_req_ff, nxt_sleep_req;
  css_pkg::css_gates_s nxt_gate;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  // bus decode
  wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  wire rd_fire = s_axi_arvalid & ~rvalid_ff;
  wire wr_map = (s_axi_awaddr == `CSS_ADDR_CTRL) |
    (s_axi_awaddr == `CSS_ADDR_STAT) | (s_axi_awaddr == `CSS_ADDR_FUSE);
  wire wr_ctrl = wr_fire & s_axi_wstrb[0] &
    (s_axi_awaddr == `CSS_ADDR_CTRL);
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  // decoded fuse views, always from the held copy
  wire css_pkg::css_source_e kind = src_kind(fuse_ff.clock_source_select);
  wire css_pkg::css_wake_e wsel = wake_sel(fuse_ff);
  wire css_pkg::css_rdly_e rsel = rdly_sel(fuse_ff);
  wire amp_prog = ~fuse_ff.oscillator_amplifier_option;
  wire [2:0] xrange = fuse_ff.clock_source_select[3:1];
  wire css_pkg::css_range_e nxt_range =
    (kind != css_pkg::CSS_SRC_CRYSTAL) ? css_pkg::CSS_RNG_NONE :
    amp_prog ? css_pkg::CSS_RNG_WIDE :
    (xrange == 3'h5) ? css_pkg::CSS_RNG_0P4 :
    (xrange == 3'h6) ? css_pkg::CSS_RNG_0P9 : css_pkg::CSS_RNG_3P0;
  // sleep mode views
  wire m_idle = mode_ff == css_pkg::CSS_SLP_IDLE;
  wire m_nr = mode_ff == css_pkg::CSS_SLP_CONV_NR;
  wire m_pd = mode_ff == css_pkg::CSS_SLP_PWR_DOWN;
  wire m_ps = mode_ff == css_pkg::CSS_SLP_PWR_SAVE;
  wire m_sb = mode_ff == css_pkg::CSS_SLP_STANDBY;
  // oscillator stops only in these, so only they need a start-up
  wire m_deep = m_pd | m_ps;
  // interrupt and address match are unclocked levels, so they act with clocks halted; the timer wake counts only while async_timer_clock runs
  wire wake_event = external_interrupt_async |
    two_wire_address_match |
    (async_timer_wake & clock_gate.async_timer_clock);
  wire in_sleep = state_ff == css_pkg::CSS_ST_SLEEP;
  wire wake_go = in_sleep & wake_event;
  wire wake_zero = wake_cnt_ff == 15'h0000;
  wire rst_zero = rst_cnt_ff == 17'h0_0000;
  wire sleep_take = (state_ff == css_pkg::CSS_ST_RUN) & sleep_req_ff;
  // state sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      css_pkg::CSS_ST_LOAD: nxt_state = css_pkg::CSS_ST_START;
      css_pkg::CSS_ST_START: begin
        if (wake_zero & rst_zero) begin
          nxt_state = css_pkg::CSS_ST_RUN;
        end
      end
      css_pkg::CSS_ST_RUN: begin
        if (sleep_req_ff) begin
          nxt_state = css_pkg::CSS_ST_SLEEP;
        end
      end
      css_pkg::CSS_ST_SLEEP: begin
        if (wake_event) begin
          nxt_state = m_deep ? css_pkg::CSS_ST_WAKE :
            css_pkg::CSS_ST_RUN;
        end
      end
      css_pkg::CSS_ST_WAKE: begin
        if (wake_zero) begin
          nxt_state = css_pkg::CSS_ST_RUN;
        end
      end
      default: nxt_state = css_pkg::CSS_ST_LOAD;
    endcase
  end
  // counters: loaded from the pins during load, then tick down
  always_comb begin
    nxt_wake_cnt = wake_cnt_ff;
    nxt_rst_cnt = rst_cnt_ff;
    if (state_ff == css_pkg::CSS_ST_LOAD) begin
      nxt_wake_cnt = wake_len(wake_sel(fuse_pins));
      nxt_rst_cnt = rdly_len(rdly_sel(fuse_pins));
    end else if (wake_go & m_deep) begin
      nxt_wake_cnt = wake_len(wsel);
    end else begin
      if (source_tick & ~wake_zero &
          (state_ff != css_pkg::CSS_ST_RUN) & ~in_sleep) begin
        nxt_wake_cnt = wake_cnt_ff - 15'h0001;
      end
      if (watchdog_osc_tick & ~rst_zero &
          (state_ff == css_pkg::CSS_ST_START)) begin
        nxt_rst_cnt = rst_cnt_ff - 17'h0_0001;
      end
    end
  end
  // domain gating, computed for the coming state
  wire n_run = nxt_state == css_pkg::CSS_ST_RUN;
  wire n_slp = nxt_state == css_pkg::CSS_ST_SLEEP;
  wire n_boot = (nxt_state == css_pkg::CSS_ST_LOAD) |
    (nxt_state == css_pkg::CSS_ST_START);
  always_comb begin
    nxt_gate.core_clock = n_run;
    nxt_gate.program_memory_clock = n_run;
    nxt_gate.peripheral_clock = n_run | (n_slp & m_idle);
    nxt_gate.converter_clock = n_run | (n_slp & (m_idle | m_nr));
    // the timer shares the oscillator pins with external sources
    nxt_gate.async_timer_clock = async_en_ff & ~n_boot &
      (kind == css_pkg::CSS_SRC_INT_RC) & ~(n_slp & (m_pd | m_sb));
  end
  // a new sleep request written as the old one is taken is kept
  assign nxt_sleep_req = (wr_ctrl & s_axi_wdata[`CSS_CTRL_SLEEP]) |
    (sleep_req_ff & ~sleep_take);
  // read mux
  wire [31:0] stat_word = {15'h0000, state_ff, execution_enable,
    oscillator_full_swing, rsel, wsel, nxt_range, kind};
  wire [31:0] ctrl_word = {27'h000_0000, sleep_req_ff, async_en_ff,
    mode_ff};
  wire [31:0] fuse_word = {25'h000_0000, fuse_ff};
  wire [31:0] rd_word = (s_axi_araddr == `CSS_ADDR_CTRL) ? ctrl_word :
    (s_axi_araddr == `CSS_ADDR_STAT) ? stat_word :
    (s_axi_araddr == `CSS_ADDR_FUSE) ? fuse_word : 32'h0000_0000;
  wire rd_map = (s_axi_araddr == `CSS_ADDR_CTRL) |
    (s_axi_araddr == `CSS_ADDR_STAT) | (s_axi_araddr == `CSS_ADDR_FUSE);
  // fsm, counters and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= css_pkg::CSS_ST_LOAD;
      wake_cnt_ff <= 15'h0000;
      rst_cnt_ff <= 17'h0_0000;
      clock_gate <= '0;
      execution_enable <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wake_cnt_ff <= nxt_wake_cnt;
      rst_cnt_ff <= nxt_rst_cnt;
      clock_gate <= nxt_gate;
      execution_enable <= n_run;
    end
  end
  // fuses: delivered values in reset, sampled once at release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_ff <= {`CSS_SEL_RST, `CSS_STARTUP_RST, `CSS_AMP_RST};
      oscillator_full_swing <= 1'b0;
      osc_range <= css_pkg::CSS_RNG_NONE;
    end else begin
      if (state_ff == css_pkg::CSS_ST_LOAD) begin
        fuse_ff <= fuse_pins;
      end
      oscillator_full_swing <= amp_prog;
      osc_range <= nxt_range;
    end
  end
  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= `CSS_MODE_RST;
      async_en_ff <= `CSS_ASYNC_RST;
      sleep_req_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_ff <= s_axi_wdata[`CSS_CTRL_MODE_LSB +: 3];
        async_en_ff <= s_axi_wdata[`CSS_CTRL_ASYNC];
      end
      sleep_req_ff <= nxt_sleep_req;
    end
  end
  // bus responses, one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `CSS_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= `CSS_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      bvalid_ff <= wr_fire | (bvalid_ff & ~s_axi_bready);
      rvalid_ff <= rd_fire | (rvalid_ff & ~s_axi_rready);
      if (wr_fire) begin
        bresp_ff <= wr_map ? `CSS_RESP_OKAY : `CSS_RESP_DECERR;
      end
      if (rd_fire) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_map ? `CSS_RESP_OKAY : `CSS_RESP_DECERR;
      end
    end
  end
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_deep_sleep_wake;
    in_sleep && m_deep && wake_event;
  endsequence
  sequence s_wake_hold;
    state_ff == css_pkg::CSS_ST_WAKE && !execution_enable;
  endsequence
  a_flash_core_pair: assert property (
    clock_gate.program_memory_clock == clock_gate.core_clock)
    else $error("program memory clock differs from core clock");
  a_core_halt_sleep: assert property (
    in_sleep |-> !clock_gate.core_clock && !execution_enable)
    else $error("core clock runs in sleep");
  a_conv_noise_mode: assert property (
    in_sleep && m_nr |-> clock_gate.converter_clock &&
    !clock_gate.peripheral_clock)
    else $error("wrong gating in converter noise mode");
  a_async_rc_only: assert property (
    clock_gate.async_timer_clock |-> kind == css_pkg::CSS_SRC_INT_RC)
    else $error("async timer clocked off internal rc");
  a_int_wake_idle: assert property (
    in_sleep && m_idle && external_interrupt_async |=>
    state_ff == css_pkg::CSS_ST_RUN && clock_gate.core_clock)
    else $error("interrupt did not wake from idle");
  a_addr_deep_wake: assert property (
    in_sleep && m_pd && two_wire_address_match |=>
    state_ff == css_pkg::CSS_ST_WAKE && wake_cnt_ff == wake_len(wsel))
    else $error("address match did not start wake count");
  a_wake_startup: assert property (
    s_deep_sleep_wake |=> s_wake_hold [*2])
    else $error("execution began before wake count");
  a_exec_counters: assert property (
    execution_enable |-> wake_zero && rst_zero)
    else $error("executing with a counter pending");
  a_fuse_held: assert property (
    state_ff != css_pkg::CSS_ST_LOAD |=> $stable(fuse_ff))
    else $error("fuses changed while running");
  a_fuse_default: assert property (
    $rose(aresetn) |-> fuse_ff == 7'h0D)
    else $error("delivered fuse value wrong");
  a_rst_delay_load: assert property (
    aresetn && state_ff == css_pkg::CSS_ST_LOAD |=> // not the reset edge
    rst_cnt_ff == rdly_len(rdly_sel($past(fuse_pins))))
    else $error("reset delay not loaded");
  a_source_decode: assert property (
    fuse_ff.clock_source_select == 4'h0 |-> kind == css_pkg::CSS_SRC_EXT_CLK)
    else $error("source decode wrong");
  a_wide_range: assert property (
    kind == css_pkg::CSS_SRC_CRYSTAL && amp_prog |=>
    osc_range == css_pkg::CSS_RNG_WIDE && oscillator_full_swing)
    else $error("crystal range not wide with full swing");
endmodule // css_clock_control
`default_nettype wire

// File: sim/css_osc_model.sv
/*
  Oscillator source model: one-cycle tick pulses for the selected
  source and for the watchdog oscillator, aligned to aclk.
  Assumes the bench sets both divide ratios to 1 or more.
*/
`timescale 1ns/1ps
`default_nettype none
module css_osc_model (
  // clock and pace
  input wire logic aclk,
  input wire logic [7:0] src_div,
  input wire logic [7:0] dog_div,
  // ticks
  output logic source_tick,
  output logic watchdog_osc_tick
);
  logic [7:0] sc = 8'h00;
  logic [7:0] dc = 8'h00;
  // free-running dividers; a slow pace is a part well under its ceiling
  always @(posedge aclk) begin
    sc <= (sc + 8'h01 >= src_div) ? 8'h00 : sc + 8'h01;
    dc <= (dc + 8'h01 >= dog_div) ? 8'h00 : dc + 8'h01;
  end
  // one tick per period; no quartz on the lowest range code
  assign source_tick = (sc == 8'h00);
  assign watchdog_osc_tick = (dc == 8'h00);
endmodule // css_osc_model
`default_nettype wire

// File: sim/tb_clock_source_select_startup.sv
/*
  Bench for css_clock_control: AXI4-Lite tasks, fuse decode,
  start-up timing and sleep gating tests.
  Assumes css_osc_model supplies the oscillator ticks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "css_params.svh"
module tb_clock_source_select_startup;
  // bench signals
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, stk, dtk, exe, swing;
  logic ext_int, addr_hit, async_wake;
  logic [3:0] awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] sdiv, wdiv;
  css_pkg::css_fuse_s fuse;
  css_pkg::css_gates_s gates;
  css_pkg::css_range_e rng;
  int mismatches, n_tests;
  // packed tables, entry i at the low end
  localparam logic [15:0] WK_P = 16'hA950;
  localparam logic [15:0] RD_P = 16'h9249;
  localparam logic [14:0] MD_P = 15'h6688;
  localparam logic [24:0] GX_P = 25'h1_0067;
  localparam logic [9:0] WS_P = 10'h190;
  logic [11:0] src_t [10] = '{12'hF86, 12'hC84, 12'hA82, 12'hE09,
    12'h990, 12'h8A0, 12'h5A0, 12'h4B0, 12'h1B0, 12'h041};

  // short counts keep the run brief
  css_clock_control #(.WAKE_LONG(15'h0014), .RST_LONG(17'h0_0028))
    css_clock_control_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fuse_pins(fuse),
    .source_tick(stk), .watchdog_osc_tick(dtk),
    .external_interrupt_async(ext_int), .two_wire_address_match(addr_hit),
    .async_timer_wake(async_wake), .clock_gate(gates),
    .execution_enable(exe), .oscillator_full_swing(swing),
    .osc_range(rng));
  css_osc_model css_osc_model_inst (.aclk(aclk), .src_div(sdiv),
    .dog_div(wdiv), .source_tick(stk), .watchdog_osc_tick(dtk));

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // compare and closing report
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo(input string nm);
    mismatches++;
    $display("[FAIL] %s expected done seen hang", nm);
    give_verdict();
  endtask
  task automatic win(input string nm, input int n, input int lo,
      input int hi);
    chk(nm, lo, (n >= lo && n <= hi) ? lo : n);
  endtask

  // fuses are presented during reset and sampled after release
  task automatic boot(input logic [6:0] f);
    @(posedge aclk);
    aresetn <= 1'b0;
    fuse <= f;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ready is sampled at the falling edge, so the decision is race free
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
      input logic [3:0] s, output logic [1:0] r);
    int n;
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
    if (n == 50) tmo("write");
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) break;
    end
    rready <= 1'b0;
    if (n == 50) tmo("read");
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m,
      input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d & m);
    chk("rresp", `CSS_RESP_OKAY, r);
  endtask

  // waits for execution_enable, sampled just after each edge
  task automatic wait_exe(input logic v, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge aclk);
      #1;
      if (exe === v) return;
    end
    tmo("execution enable");
  endtask

  // main sequence
  initial begin
    int n, i;
    logic [31:0] d;
    logic [1:0] r;
    logic [11:0] e;
    mismatches = 0;
    n_tests = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wstrb, araddr, wdata} = 44'h000_0000_0000;
    {ext_int, addr_hit, async_wake} = 3'b000;
    fuse = 7'h0D;
    sdiv = 8'h01;
    wdiv = 8'h03;
    // delivered fuses: reset delay runs on the slow watchdog ticks
    boot(7'h0D);
    wait_exe(1'b1, 200, n);
    win("reset delay", n, 114, 126);
    rdc(`CSS_ADDR_FUSE, 32'h0000_007F, 32'h0000_000D, "fuse");
    fuse <= 7'h00;
    rdc(`CSS_ADDR_CTRL, 32'h0000_001F, 32'h0000_0000, "ctrl reset");
    rd(4'hC, d, r);
    chk("rresp unmapped", `CSS_RESP_DECERR, r);
    chk("rdata unmapped", 32'h0000_0000, d);
    wr(4'hC, 32'h0000_0012, 4'hF, r);
    chk("bresp unmapped", `CSS_RESP_DECERR, r);
    wr(`CSS_ADDR_STAT, 32'hFFFF_FFFF, 4'hF, r);
    chk("bresp stat", `CSS_RESP_OKAY, r);
    wr(`CSS_ADDR_CTRL, 32'h0000_0012, 4'h0, r);
    rdc(`CSS_ADDR_CTRL, 32'h0000_001F, 32'h0000_0000, "ctrl no lane");
    rdc(`CSS_ADDR_STAT, 32'h0001_FFFF, 32'h0000_4AC3, "stat");
    rdc(`CSS_ADDR_FUSE, 32'h0000_007F, 32'h0000_000D, "held");
    $display("test defaults done");
    // source kind, crystal range and swing per select code
    for (i = 0; i < 10; i++) begin
      e = src_t[i];
      boot({e[11:8], 2'b10, e[7]});
      @(posedge aclk); // swing flop follows the sampled fuses an edge late
      rdc(`CSS_ADDR_STAT, 32'h0000_043F,
        {21'd0, e[0], 4'd0, e[3:1], e[6:4]}, "source");
      chk("range", {29'd0, e[3:1]}, {29'd0, rng});
      chk("swing", {31'd0, e[0]}, {31'd0, swing});
    end
    $display("test source decode done");
    // crystal wake count and reset delay per low bit and startup code
    for (i = 0; i < 8; i++) begin
      boot({3'b111, i[2:0], 1'b1});
      rdc(`CSS_ADDR_STAT, 32'h0000_03C0, {22'd0, RD_P[2*i +: 2],
        WK_P[2*i +: 2], 6'd0}, "crystal");
    end
    $display("test crystal table done");
    // crystal power-down: wake waits out the full source count
    sdiv <= 8'h02;
    boot(7'h7B);
    wait_exe(1'b1, 100, n);
    win("crystal start", n, 38, 46);
    wr(`CSS_ADDR_CTRL, 32'h0000_0008, 4'h1, r);
    wait_exe(1'b1, 5, n);
    chk("async off", 32'h0000_001D, {27'd0, gates});
    wr(`CSS_ADDR_CTRL, 32'h0000_001A, 4'h1, r);
    wait_exe(1'b0, 10, n);
    chk("down gates", 32'h0000_0000, {27'd0, gates});
    @(posedge aclk);
    ext_int <= 1'b1;
    wait_exe(1'b1, 100, n);
    win("crystal wake", n, 38, 46);
    @(posedge aclk);
    ext_int <= 1'b0;
    $display("test crystal wake done");
    // every sleep mode under the internal oscillator, async timer on
    sdiv <= 8'h03;
    boot(7'h09);
    wait_exe(1'b1, 100, n);
    wr(`CSS_ADDR_CTRL, 32'h0000_0008, 4'h1, r);
    wait_exe(1'b1, 5, n);
    chk("run gates", 32'h0000_001F, {27'd0, gates});
    for (i = 0; i < 5; i++) begin
      wr(`CSS_ADDR_CTRL, {27'd0, 2'b11, MD_P[3*i +: 3]}, 4'h1, r);
      wait_exe(1'b0, 10, n);
      chk("sleep gates", {27'd0, GX_P[5*i +: 5]},
        {27'd0, gates});
      @(posedge aclk);
      {ext_int, addr_hit, async_wake} <= 3'b100 >> WS_P[2*i +: 2];
      wait_exe(1'b1, 60, n);
      if (i == 2 || i == 3) win("slow wake", n, 15, 24);
      else win("fast wake", n, 0, 2);
      @(posedge aclk);
      {ext_int, addr_hit, async_wake} <= 3'b000;
    end
    $display("test sleep modes done");
    give_verdict();
  end
endmodule // tb_clock_source_select_startup
`default_nettype wire
